/* File: verilog/slrf_rx_framer.sv */
// Receive framer, decoder, self-test checker and register slave
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
module slrf_rx_framer #(
  parameter int ERR_W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic serial_in_a,
  input wire logic serial_in_b,
  input wire logic serial_in_b_n,
  input wire logic status_in,
  output logic status_out,
  output logic recovered_byte_clock,
  output logic [7:0] parallel_out,
  output logic char_kind_flag,
  output logic violation_flag,
  output logic out_ready_n,
  input wire logic [slrf_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [slrf_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import slrf_pkg::*;

  slrf_ctrl_t ctrl_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic tclk_prev_q;
  logic status_q;
  logic [9:0] sh_q;
  logic [9:0] sh_d;
  logic [3:0] bit_cnt_q;
  logic [3:0] bit_cnt_d;
  logic rck_q;
  logic [10:0] rf_cnt_q;
  logic dbl_q;
  logic prev_comma_q;
  slrf_st_t st_q;
  logic [8:0] lfsr_q;
  logic [8:0] loop_cnt_q;
  logic [ERR_W-1:0] err_cnt_q;
  slrf_out_t out_q;
  slrf_out_t out_d;
  slrf_out_t out_p_q;
  logic stb_q;
  slrf_dec_t dec;
  logic line_bit;
  logic b_data;
  logic bit_en;
  logic comma_hit;
  logic realign;
  logic sym_stb;
  logic is_null;
  logic [7:0] expect_byte;
  logic st_match;
  logic aw_have_q;
  logic w_have_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic do_write;
  logic [31:0] stat_word;

  // Symbol decoder: 6b and 4b lookup, direct codes before complements
  function automatic slrf_dec_t decode(input logic [9:0] s);
    slrf_dec_t r;
    logic hit6;
    logic hit4;
    logic alt4;
    r = '0;
    hit6 = 1'b0;
    hit4 = 1'b0;
    alt4 = (s[3:0] == ALT7_NEG) || (s[3:0] == ~ALT7_NEG);
    for (int i = 0; i < 32; i++) begin
      if (!hit6 && s[9:4] == TAB6[i]) begin
        hit6 = 1'b1;
        r.data[4:0] = 5'(i);
      end
    end
    for (int i = 0; i < 32; i++) begin
      if (!hit6 && s[9:4] == ~TAB6[i]) begin
        hit6 = 1'b1;
        r.data[4:0] = 5'(i);
      end
    end
    if (s[9:4] == K28_NEG || s[9:4] == ~K28_NEG) begin
      hit6 = 1'b1;
      r.data[4:0] = 5'h1c;
      r.kind = 1'b1;
    end
    for (int i = 0; i < 8; i++) begin
      if (!hit4 && s[3:0] == TAB4[i]) begin
        hit4 = 1'b1;
        r.data[7:5] = 3'(i);
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (!hit4 && s[3:0] == ~TAB4[i]) begin
        hit4 = 1'b1;
        r.data[7:5] = 3'(i);
      end
    end
    if (alt4) begin
      hit4 = 1'b1;
      r.data[7:5] = 3'h7;
      if (r.data[4:0] == 5'h17 || r.data[4:0] == 5'h1b ||
          r.data[4:0] == 5'h1d || r.data[4:0] == 5'h1e) begin
        r.kind = 1'b1;
      end
    end
    r.viol = !(hit6 && hit4);
    return r;
  endfunction

  // Two-stage synchroniser for the line and status pin inputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else if (ce) begin
      sync1_q <= {status_in, serial_in_b_n, serial_in_b, serial_in_a};
      sync2_q <= sync1_q;
    end
  end

  // Status translation, or held high when the pair is differential
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_q <= 1'b0;
    end else if (ce) begin
      status_q <= ctrl_q.status_tie ? 1'b1 : sync2_q[3];
    end
  end
  assign status_out = status_q;

  // Line input selection and bit enable
  assign b_data = ctrl_q.status_tie ? (sync2_q[1] & ~sync2_q[2])
                                    : sync2_q[1];
  assign line_bit = (ctrl_q.mode == MODE_TEST || ctrl_q.input_select) ?
                    sync2_q[0] : b_data;
  assign bit_en = ce && ((ctrl_q.mode == MODE_TEST) ?
                  (sync2_q[1] && !tclk_prev_q) : 1'b1);

  // Edge detector state for the external test bit clock
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tclk_prev_q <= 1'b0;
    end else if (ce) begin
      tclk_prev_q <= sync2_q[1];
    end
  end

  // Comma detection and boundary decision
  assign sh_d = {sh_q[8:0], line_bit};
  assign comma_hit = (sh_d == COMMA_NEG) || (sh_d == COMMA_POS);
  assign realign = ctrl_q.reframe_en && comma_hit &&
                   (!dbl_q || prev_comma_q);
  assign sym_stb = bit_en && (bit_cnt_q == BIT_LAST || realign);
  assign bit_cnt_d = sym_stb ? 4'h0 : bit_cnt_q + 4'h1;

  // Deserialiser and byte counter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sh_q <= 10'h000;
      bit_cnt_q <= 4'h0;
    end else if (bit_en) begin
      sh_q <= sh_d;
      bit_cnt_q <= bit_cnt_d;
    end
  end

  // Byte clock drops at each strobe so a mid-byte realign still rises
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rck_q <= 1'b0;
    end else if (sym_stb) begin
      rck_q <= 1'b0;
    end else if (ce && stb_q) begin
      rck_q <= 1'b1;
    end else if (bit_en && bit_cnt_d > CLK_HIGH_BITS) begin
      rck_q <= 1'b0;
    end
  end
  assign recovered_byte_clock = rck_q;

  // Reframe byte count, double-byte framing and comma history
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rf_cnt_q <= 11'h000;
      dbl_q <= 1'b0;
      prev_comma_q <= 1'b0;
    end else if (ce && !ctrl_q.reframe_en) begin
      rf_cnt_q <= 11'h000;
      dbl_q <= 1'b0;
    end else if (sym_stb) begin
      prev_comma_q <= comma_hit;
      if (rf_cnt_q == RF_LAST) begin
        dbl_q <= 1'b1;
      end else begin
        rf_cnt_q <= rf_cnt_q + 11'h001;
      end
    end
  end

  // Self-test expectation for the current loop position
  assign dec = decode(sh_d);
  assign expect_byte = (loop_cnt_q == 9'h000) ? START_BYTE : lfsr_q[7:0];
  assign st_match = !dec.viol && !dec.kind && dec.data == expect_byte;

  // Self-test sequencer: wait for start byte, then run the loop
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      lfsr_q <= LFSR_SEED;
      loop_cnt_q <= 9'h000;
    end else if (ce && ctrl_q.selftest_en_n) begin
      st_q <= ST_IDLE;
    end else if (ce) begin
      case (st_q)
        ST_IDLE: begin
          st_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (sym_stb && !dec.viol && !dec.kind && dec.data == START_BYTE) begin
            st_q <= ST_RUN;
            lfsr_q <= LFSR_SEED;
            loop_cnt_q <= 9'h001;
          end
        end
        ST_RUN: begin
          if (sym_stb && loop_cnt_q == LOOP_LAST) begin
            loop_cnt_q <= 9'h000;
            lfsr_q <= LFSR_SEED;
          end else if (sym_stb) begin
            loop_cnt_q <= loop_cnt_q + 9'h001;
            if (loop_cnt_q != 9'h000) begin
              lfsr_q <= {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Saturating self-test mismatch counter
  always_ff @(posedge mclk) begin
    if (!rst_n || (ce && st_q != ST_RUN)) begin
      err_cnt_q <= '0;
    end else if (sym_stb && !st_match && err_cnt_q != '1) begin
      err_cnt_q <= err_cnt_q + 1'b1;
    end
  end

  // Output word selection per mode
  assign is_null = (ctrl_q.mode == MODE_RAW) ? comma_hit :
                   (dec.kind && dec.data == NULL_BYTE);
  always_comb begin
    out_d.ready_n = is_null;
    out_d.kind = dec.kind;
    out_d.viol = dec.viol;
    out_d.data = dec.data;
    if (ctrl_q.mode == MODE_RAW) begin
      out_d.data = sh_d[8:1];
      out_d.kind = sh_d[9];
      out_d.viol = sh_d[0];
    end else if (st_q == ST_RUN) begin
      out_d.viol = !st_match;
      out_d.ready_n = (loop_cnt_q == LOOP_LAST);
    end
  end

  // Output word staged at the strobe, shown as the byte clock rises
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stb_q <= 1'b0;
      out_p_q <= '{1'b1, 1'b0, 1'b0, 8'h00};
      out_q <= '{1'b1, 1'b0, 1'b0, 8'h00};
    end else if (ce) begin
      stb_q <= sym_stb;
      if (sym_stb) begin
        out_p_q <= out_d;
      end
      if (stb_q) begin
        out_q <= out_p_q;
      end
    end
  end
  assign parallel_out = out_q.data;
  assign char_kind_flag = out_q.kind;
  assign violation_flag = out_q.viol;
  assign out_ready_n = out_q.ready_n;

  // Register bus: write address and data taken in either order
  assign s_axi_awready = ce && !aw_have_q;
  assign s_axi_wready = ce && !w_have_q;
  assign do_write = ce && aw_have_q && w_have_q && !bvalid_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
    end
  end

  // Control register update and write response
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (awaddr_q[AXI_AW-1:2] == CTRL_OFF[AXI_AW-1:2] ||
                  awaddr_q[AXI_AW-1:2] == STAT_OFF[AXI_AW-1:2]) ?
                 RESP_OKAY : RESP_SLVERR;
      if (awaddr_q[AXI_AW-1:2] == CTRL_OFF[AXI_AW-1:2] && wstrb0_q) begin
        ctrl_q <= slrf_ctrl_t'(wdata_q[5:0]);
      end
    end else if (ce && bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read channel: one word per request, unmapped reads zero with error
  assign stat_word = {err_cnt_q, 3'h0, (st_q == ST_RUN), dbl_q,
                      out_q.ready_n, out_q.viol, out_q.kind, out_q.data};
  assign s_axi_arready = ce && !rvalid_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (ce && s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      if (s_axi_araddr[AXI_AW-1:2] == CTRL_OFF[AXI_AW-1:2]) begin
        rdata_q <= {26'h0, ctrl_q};
      end else if (s_axi_araddr[AXI_AW-1:2] == STAT_OFF[AXI_AW-1:2]) begin
        rdata_q <= stat_word;
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= RESP_SLVERR;
      end
    end else if (ce && rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Checks on framing, mapping and handshake timing
  out_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(out_q) |-> $past(stb_q))
    else $error("output changed outside a symbol strobe");
  rck_edge_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(out_q) |-> $rose(rck_q))
    else $error("output changed without byte clock rise");
  raw_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (sym_stb && ctrl_q.mode == MODE_RAW) |=> ##1
      (out_q.data == $past(sh_d[8:1], 2) &&
       out_q.kind == $past(sh_d[9], 2) &&
       out_q.viol == $past(sh_d[0], 2)))
    else $error("raw mode bits misplaced");
  null_skip_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (sym_stb && ctrl_q.mode == MODE_ENC && st_q != ST_RUN &&
     sh_d == COMMA_NEG) |=> ##1 (out_q.ready_n && out_q.kind &&
                                 out_q.data == NULL_BYTE))
    else $error("null character not decoded or ready pulsed");
  data_ready_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (sym_stb && ctrl_q.mode == MODE_ENC && st_q != ST_RUN && !is_null) |=>
      ##1 !out_q.ready_n)
    else $error("ready missing for data byte");
  reframe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (bit_en && ctrl_q.reframe_en && !dbl_q && comma_hit) |=>
      (bit_cnt_q == 4'h0 && sh_q == $past(sh_d)))
    else $error("comma did not realign the byte boundary");
  free_run_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (bit_en && !ctrl_q.reframe_en && bit_cnt_q != BIT_LAST) |=>
      bit_cnt_q == $past(bit_cnt_q) + 4'h1)
    else $error("byte counter disturbed with reframing off");
  dbl_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (sym_stb && ctrl_q.reframe_en && rf_cnt_q == RF_LAST) |=> dbl_q)
    else $error("double-byte framing not entered");
  test_pass_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (sym_stb && ctrl_q.mode == MODE_ENC && st_q == ST_RUN && st_match) |=>
      ##1 !out_q.viol)
    else $error("matching self-test byte flagged");
  loop_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (sym_stb && ctrl_q.mode == MODE_ENC && st_q == ST_RUN) |=>
      ##1 (out_q.ready_n == ($past(loop_cnt_q, 2) == LOOP_LAST)))
    else $error("self-test ready level wrong");
  test_clk_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ctrl_q.mode == MODE_TEST && bit_en) |-> $rose(sync2_q[1]))
    else $error("test mode bit taken without test clock edge");
  status_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && !ctrl_q.status_tie) |=> status_out == $past(sync2_q[3]))
    else $error("status output does not follow status input");
endmodule

/* File: verilog/slrf_pkg.sv */
// Constants and types shared by the serial link receiver framer
package slrf_pkg;
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] CTRL_OFF = 4'h0;
  localparam logic [AXI_AW-1:0] STAT_OFF = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] BIT_LAST = 4'h9;
  localparam logic [3:0] CLK_HIGH_BITS = 4'h5;
  localparam int REFRAME_BYTES = 2048;
  localparam logic [10:0] RF_LAST = 11'(REFRAME_BYTES - 1);
  localparam int LOOP_BYTES = 511;
  localparam logic [8:0] LOOP_LAST = 9'(LOOP_BYTES - 1);
  localparam logic [8:0] LFSR_SEED = 9'h001;
  localparam logic [9:0] COMMA_NEG = 10'h0fa;
  localparam logic [9:0] COMMA_POS = 10'h305;
  localparam logic [7:0] NULL_BYTE = 8'hbc;
  localparam logic [7:0] START_BYTE = 8'h00;
  localparam logic [5:0] K28_NEG = 6'h0f;
  localparam logic [3:0] ALT7_NEG = 4'h7;
  localparam logic [5:0] TAB6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] TAB4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  typedef enum logic [1:0] {MODE_ENC, MODE_RAW, MODE_TEST} slrf_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} slrf_st_t;

  typedef struct packed {
    logic status_tie;
    logic selftest_en_n;
    logic reframe_en;
    logic input_select;
    slrf_mode_t mode;
  } slrf_ctrl_t;

  localparam slrf_ctrl_t CTRL_RESET = '{1'b0, 1'b1, 1'b1, 1'b1, MODE_ENC};

  typedef struct packed {
    logic kind;
    logic viol;
    logic [7:0] data;
  } slrf_dec_t;

  typedef struct packed {
    logic ready_n;
    logic kind;
    logic viol;
    logic [7:0] data;
  } slrf_out_t;
endpackage

/* File: test/slrf_tx_model.sv */
// Serial transmitter model: sends queued symbols, commas when idle
`timescale 1ns/1ps
module slrf_tx_model (
  input wire logic mclk,
  input wire logic rst_n,
  output logic ser
);
  import slrf_pkg::*;
  logic [10:0] q[$];
  logic [10:0] nx;
  logic [9:0] sh_q;
  logic [3:0] cnt_q;
  // Bit a leaves first; entry bit 10 marks a three-bit slip of ones
  always @(posedge mclk) begin
    if (!rst_n) begin
      sh_q <= COMMA_NEG;
      cnt_q <= 4'h0;
      ser <= 1'b0;
    end else begin
      ser <= sh_q[9];
      if (cnt_q == BIT_LAST) begin
        nx = (q.size() > 0) ? q.pop_front() : {1'b0, COMMA_NEG};
        sh_q <= nx[9:0];
        cnt_q <= nx[10] ? 4'h7 : 4'h0;
      end else begin
        sh_q <= sh_q << 1;
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

/* File: test/tb.sv */
// Self-checking bench for the serial link receiver framer
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((e) !== (s)) begin \
  miscompares++; $display("FAIL %s exp %h got %h", nm, e, s); end end
module tb;
  import slrf_pkg::*;
  typedef struct packed {
    slrf_out_t m;
    slrf_out_t e;
  } slrf_item_t;
  localparam slrf_out_t ALL = 11'h7ff;
  localparam slrf_out_t NUL_E = {3'b110, NULL_BYTE};
  localparam slrf_out_t RAWC = {1'b1, COMMA_NEG[9], COMMA_NEG[0],
    COMMA_NEG[8:1]};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic line_sel = 1'b1;
  logic tgl = 1'b0;
  logic status_in = 1'b0;
  logic st_chk = 1'b0;
  logic ser, pb, pr, rise, hd;
  logic [2:0] st_h;
  logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic serial_in_a, serial_in_b, serial_in_b_n, status_out;
  logic recovered_byte_clock, char_kind_flag, violation_flag, out_ready_n;
  logic [7:0] parallel_out;
  slrf_out_t o, po;
  int miscompares = 0, n_tests = 0, seed = 32'ha356;
  slrf_item_t xq[$];

  always #5 mclk = ~mclk;
  // Unselected line carries a toggle pattern that never forms a comma
  always @(posedge mclk) tgl <= ~tgl;
  assign serial_in_a = line_sel ? ser : tgl;
  assign serial_in_b = line_sel ? tgl : ser;
  assign serial_in_b_n = ~serial_in_b;

  slrf_tx_model i_tx (.mclk, .rst_n, .ser);
  slrf_rx_framer i_dut (.mclk, .rst_n, .ce(1'b1), .serial_in_a,
    .serial_in_b, .serial_in_b_n, .status_in, .status_out,
    .recovered_byte_clock, .parallel_out, .char_kind_flag,
    .violation_flag, .out_ready_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic tmo();
    miscompares++;
    $display("FAIL wait exp done got timeout");
    finish_test();
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] er);
    int n;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) tmo();
    `CHK("bresp", er, s_axi_bresp)
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m,
      input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 50) tmo();
    `CHK("rdata", ed, s_axi_rdata & m)
    `CHK("rresp", er, s_axi_rresp)
  endtask

  // Queue a symbol at the model and its expected output at the checker
  task automatic tx(input logic [9:0] s, input slrf_out_t e,
      input slrf_out_t m);
    i_tx.q.push_back({1'b0, s});
    xq.push_back({m, e});
  endtask

  task automatic dat(input logic [7:0] d);
    tx({TAB6[d[4:0]], TAB4[d[7:5]]}, {3'b000, d}, ALL);
  endtask

  task automatic lead();
    repeat (60) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic drain();
    int n;
    for (n = 0; n < 4000 && xq.size() > 0; n++) @(posedge mclk);
    if (xq.size() > 0) tmo();
  endtask

  // Compare at byte clock rises; idle nulls ahead of data are skipped
  always @(posedge mclk) begin
    o = {out_ready_n, char_kind_flag, violation_flag, parallel_out};
    rise = recovered_byte_clock && !pb;
    hd = xq.size() > 0;
    if (rst_n && pr) begin
      if (rise && hd) begin
        if (!(o.ready_n === 1'b1 && xq[0].m.ready_n && !xq[0].e.ready_n))
            begin
          `CHK("byte", xq[0].e & xq[0].m, o & xq[0].m)
          void'(xq.pop_front());
        end
      end else if (hd && !rise && o !== po) begin
        `CHK("hold", po, o)
      end
      if (st_chk) `CHK("status", st_h[2], status_out)
    end
    st_h = {st_h[1:0], status_in};
    pb = recovered_byte_clock;
    po = o;
    pr = rst_n;
  end

  initial begin
    logic [9:0] s;
    logic [8:0] l;
    int i, j;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(CTRL_OFF, 32'h3f, 32'h1c, RESP_OKAY);
    rd(4'h8, 32'hffffffff, 32'h0, RESP_SLVERR);
    wr(4'h8, 32'h0, RESP_SLVERR);
    wr(STAT_OFF, 32'hffff, RESP_OKAY);
    rd(STAT_OFF, 32'h800, 32'h0, RESP_OKAY);
    // Slip the line by three bits, let the framer relock, then check
    for (i = 0; i < 2; i++) begin
      @(negedge mclk);
      i_tx.q.push_back(11'h7ff);
      lead();
      tx(COMMA_NEG, NUL_E, ALL);
      dat(8'h00);
      dat(8'h55);
      dat(8'h00);
      drain();
    end
    repeat (20600) @(posedge mclk);
    rd(STAT_OFF, 32'h800, 32'h800, RESP_OKAY);
    wr(CTRL_OFF, 32'h14, RESP_OKAY);
    rd(STAT_OFF, 32'h800, 32'h0, RESP_OKAY);
    // Every byte value, bad groups, then a null, framed by the counter
    lead();
    tx(COMMA_NEG, NUL_E, ALL);
    for (i = 0; i < 256; i++) dat(i[7:0]);
    tx(10'h00b, 11'h100, 11'h100);
    tx(10'h270, 11'h100, 11'h100);
    tx(COMMA_NEG, NUL_E, ALL);
    drain();
    // Raw symbols over line A, then over line B
    for (j = 0; j < 2; j++) begin
      line_sel <= (j == 0);
      wr(CTRL_OFF, (j == 0) ? 32'h15 : 32'h11, RESP_OKAY);
      lead();
      tx(COMMA_NEG, RAWC, ALL);
      for (i = 0; i < 64; i++) begin
        s = 10'($random(seed));
        if (s == COMMA_NEG || s == COMMA_POS) s = 10'h155;
        tx(s, {1'b0, s[9], s[0], s[8:1]}, ALL);
      end
      drain();
    end
    // Self-test: start byte, then the local pattern, every byte passing
    line_sel <= 1'b1;
    wr(CTRL_OFF, 32'h04, RESP_OKAY);
    lead();
    dat(8'h00);
    l = LFSR_SEED;
    for (i = 0; i < 40; i++) begin
      dat(l[7:0]);
      l = {l[7:0], l[8] ^ l[4]};
    end
    drain();
    rd(STAT_OFF, 32'h1000, 32'h1000, RESP_OKAY);
    st_chk <= 1'b1;
    repeat (40) begin
      @(posedge mclk);
      status_in <= 1'($random(seed));
    end
    st_chk <= 1'b0;
    wr(CTRL_OFF, 32'h31, RESP_OKAY);
    repeat (6) @(posedge mclk);
    `CHK("status_tie", 1'b1, status_out)
    finish_test();
  end
endmodule
